// File: smc_map.vh
// constants for the static memory read and byte lane block
// Operation
// RULE1: drive 26 address lines, 64 Mbyte per select
// RULE2: significant address bits follow selected bus width
// RULE3: each select has own 8/16/32 width
// RULE4: 16/32-bit selects pick byte-write or byte-select
// RULE5: byte-write: one write strobe per lane
// RULE6: no boot from byte-write select
// RULE7: byte-select: one lane select per byte
// RULE8: shared pins translate by width and access type
// RULE9: unused address bits and strobes stay idle
// RULE10: lane selects time like address bus
// RULE11: read starts with width-appropriate address
// RULE12: read strobe setup, pulse, then hold
// RULE13: chip select has own read timing
// RULE14: hold derived as cycle minus setup minus pulse
// RULE15: timings in clock cycles, per select
// RULE16: zero setup/hold keeps strobes low back-to-back
// RULE17: software programs every pulse at least one
// RULE18: read-control bit picks capturing signal
// RULE19: mode 1 captures at read strobe rise
// RULE20: mode 0 captures at chip select rise
// RULE21: software hands pins to memory function first
// RULE22: six active-low chip selects, 0 to 5
// RULE23: decode address to select, apply its settings
`ifndef SMC_MAP_VH
`define SMC_MAP_VH
`define SMC_NUM_SEL    6
`define SMC_ADDR_W     26
`define SMC_SEL_LSB    26
`define SMC_SEL_W      3
`define SMC_TIME_W     10
`define SMC_WIDTH_8    2'h0
`define SMC_WIDTH_16   2'h1
`define SMC_WIDTH_32   2'h2
`define SMC_SIZE_BYTE  2'h0
`define SMC_SIZE_HALF  2'h1
`define SMC_SIZE_WORD  2'h2
`define SMC_BAT_SELECT 1'b0
`define SMC_BAT_WRITE  1'b1
`endif

// File: smr_asserts.sv
// checker for the static memory read engine
`timescale 1ns/1ps
module smr_asserts #(
    parameter NSEL = 6,
    parameter TW   = 10
) (
    // clock and reset
    input wire               clk,
    input wire               sys_rst,
    // per select settings
    input wire [2*NSEL-1:0]  bus_width_field,
    input wire [NSEL-1:0]    byte_access_type,
    input wire [NSEL-1:0]    read_mode,
    input wire [TW*NSEL-1:0] read_strobe_setup,
    input wire [TW*NSEL-1:0] read_strobe_pulse,
    input wire [TW*NSEL-1:0] select_read_setup,
    input wire [TW*NSEL-1:0] select_read_pulse,
    input wire [TW*NSEL-1:0] read_cycle_length,
    input wire               boot_from_select0,
    // request side
    input wire [31:0]        req_addr,
    input wire [1:0]         req_size,
    input wire               req_ready,
    input wire               read_valid,
    input wire               read_error,
    // memory pins
    input wire [NSEL-1:0]    chip_select_n,
    input wire               read_strobe_n,
    input wire [25:2]        mem_addr,
    input wire               a0_lane0_select_n,
    input wire               write_strobe_n,
    input wire               lane1_strobe_n,
    input wire               a1_lane2_strobe_n,
    input wire               lane3_strobe_n
);
    reg  [31:0]   a_q;
    reg  [1:0]    z_q;
    reg  [2:0]    s_reg;
    reg  [10:0]   cnt_reg;
    // request seen at the taking edge, so pins can be judged in the ready cycle
    always @(posedge clk) begin
        a_q <= req_addr;
        z_q <= req_size;
        if (sys_rst) begin
            cnt_reg <= 11'h7FF;
            s_reg   <= 3'h0;
        end else if (req_ready) begin
            // the ready cycle is count 0, so the next one is count 1
            cnt_reg <= 11'h001;
            s_reg   <= a_q[28:26];
        end else if (~&cnt_reg) begin
            cnt_reg <= cnt_reg + 11'h001;
        end
    end
    wire [2:0]    t    = a_q[28:26];
    wire          ok_t = t < NSEL;
    wire [1:0]    wd   = bus_width_field[2*t +: 2];
    wire          bw   = byte_access_type[t] && !(boot_from_select0 && t == 3'h0);
    // a cycle taken on the last edge of the previous one starts in the ready cycle
    wire [2:0]    sc   = req_ready ? t : s_reg;
    wire [10:0]   cc   = req_ready ? 11'h000 : cnt_reg;
    wire [TW-1:0] rs   = read_strobe_setup[TW*sc +: TW];
    wire [TW-1:0] rp   = read_strobe_pulse[TW*sc +: TW];
    wire [TW-1:0] cs   = select_read_setup[TW*sc +: TW];
    wire [TW-1:0] cp   = select_read_pulse[TW*sc +: TW];
    wire          act  = sc < NSEL && cc < read_cycle_length[TW*sc +: TW];
    wire [10:0]   gov  = read_mode[sc] ? rs + rp : cs + cp;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence cap_s;
        act && cc + 11'h001 == gov;
    endsequence
    a_reset_idle: assert property ($fell(sys_rst) |-> &chip_select_n && read_strobe_n
        && !read_valid && !req_ready) else $error("pins active after reset");
    a_write_idle: assert property (write_strobe_n) else $error("write strobe low");
    a_one_select: assert property ($onehot0(~chip_select_n)) else $error("two selects");
    a_addr_taken: assert property (req_ready |-> mem_addr == a_q[25:2])
        else $error("address not taken");
    a_narrow_addr: assert property (req_ready && ok_t && wd == 2'h0 |->
        a0_lane0_select_n == a_q[0] && a1_lane2_strobe_n == a_q[1]) else $error("low address");
    a_select_lanes: assert property (req_ready && ok_t && wd != 2'h0 && !bw && z_q == 2'h2
        |-> !a0_lane0_select_n && !lane1_strobe_n && (wd == 2'h1 ?
        a1_lane2_strobe_n == a_q[1] && lane3_strobe_n : !a1_lane2_strobe_n && !lane3_strobe_n))
        else $error("lane selects");
    a_write_lanes: assert property (req_ready && ok_t && wd != 2'h0 && bw |->
        a0_lane0_select_n && lane1_strobe_n && lane3_strobe_n &&
        (wd == 2'h1 ? a1_lane2_strobe_n == a_q[1] : a1_lane2_strobe_n)) else $error("lanes used");
    a_strobe_shape: assert property (act |->
        read_strobe_n == !(cc >= rs && cc < rs + rp)) else $error("read strobe");
    a_select_shape: assert property (act |->
        chip_select_n[sc] == !(cc >= cs && cc < cs + cp)) else $error("select");
    a_capture_edge: assert property (cap_s |=> read_valid && !read_error)
        else $error("capture edge");
    a_bad_select: assert property (req_ready && !ok_t |-> ##[0:3] (read_valid && read_error))
        else $error("bad select");
endmodule // smr_asserts
bind static_memory_read smr_asserts #(.NSEL(NSEL), .TW(TW)) u_chk (.*);

// File: sram_model.sv
// behavioural static memory on the far side of the read engine
`timescale 1ns/1ps
module sram_model (
    // memory pins
    input  wire [5:0]  chip_select_n,
    input  wire        read_strobe_n,
    input  wire [25:2] mem_addr,
    // data bus back to the engine
    output wire [31:0] mem_data_in
);
    wire [31:0] word = {8'hC3, mem_addr};
    // outputs only with both enables low; else inverted, so a mistimed capture shows
    assign mem_data_in = (!read_strobe_n && !(&chip_select_n)) ? word : ~word;
endmodule // sram_model

// File: static_memory_read.v
// static memory read cycle engine with byte lane pin multiplexing
`timescale 1ns/1ps
`include "smc_map.vh"

module static_memory_read #(
    parameter NSEL = `SMC_NUM_SEL,
    parameter TW   = `SMC_TIME_W
) (
    // clock and reset
    input  wire                 clk,
    input  wire                 sys_rst,
    // per select configuration, select i in slice i
    input  wire [2*NSEL-1:0]    bus_width_field,
    input  wire [NSEL-1:0]      byte_access_type,
    input  wire [NSEL-1:0]      read_mode,
    input  wire [TW*NSEL-1:0]   read_strobe_setup,
    input  wire [TW*NSEL-1:0]   read_strobe_pulse,
    input  wire [TW*NSEL-1:0]   select_read_setup,
    input  wire [TW*NSEL-1:0]   select_read_pulse,
    input  wire [TW*NSEL-1:0]   read_cycle_length,
    input  wire                 boot_from_select0,
    // read request side
    input  wire                 req_valid,
    input  wire [31:0]          req_addr,
    input  wire [1:0]           req_size,
    output reg                  req_ready,
    output reg  [31:0]          read_data,
    output reg                  read_valid,
    output reg                  read_error,
    // memory side
    output reg  [NSEL-1:0]      chip_select_n,
    output reg                  read_strobe_n,
    output reg  [25:2]          mem_addr,
    output reg                  a0_lane0_select_n,
    output reg                  write_strobe_n,
    output reg                  lane1_strobe_n,
    output reg                  a1_lane2_strobe_n,
    output reg                  lane3_strobe_n,
    input  wire [31:0]          mem_data_in
);

    localparam ST_IDLE = 1'b0;
    localparam ST_READ = 1'b1;

    // strobe low while count lies in [setup, setup+pulse)
    function in_window;
        input [TW-1:0] c;
        input [TW-1:0] s;
        input [TW-1:0] p;
        reg   [TW:0]   e;
        begin
            e = {1'b0, s} + {1'b0, p};
            in_window = (c >= s) && ({1'b0, c} < e);
        end
    endfunction

    // reserved width code behaves as 32-bit
    function [1:0] width_of;
        input [1:0] w;
        begin
            if (w == `SMC_WIDTH_8 || w == `SMC_WIDTH_16) begin
                width_of = w;
            end else begin
                width_of = `SMC_WIDTH_32;
            end
        end
    endfunction

    // active-high lanes touched by a read of given size
    function [3:0] lane_mask;
        input [1:0] size;
        input [1:0] a;
        input [1:0] w;
        begin
            if (size == `SMC_SIZE_BYTE) begin
                lane_mask = 4'h1 << a;
            end else if (size == `SMC_SIZE_HALF) begin
                lane_mask = a[1] ? 4'hC : 4'h3;
            end else begin
                lane_mask = 4'hF;
            end
            if (width_of(w) == `SMC_WIDTH_16) begin
                lane_mask = {2'h0, lane_mask[3:2] | lane_mask[1:0]};
            end
        end
    endfunction

    reg            state_reg;
    reg  [TW-1:0]  cnt_reg;
    reg  [2:0]     sel_reg;
    reg  [1:0]     width_reg;
    reg            mode_reg;
    reg  [TW-1:0]  rs_reg;
    reg  [TW-1:0]  rp_reg;
    reg  [TW-1:0]  cs_reg;
    reg  [TW-1:0]  cp_reg;
    reg  [TW-1:0]  cyc_reg;

    reg            state_next;
    reg  [TW-1:0]  cnt_next;
    reg  [2:0]     sel_next;
    reg            mode_next;
    reg  [TW-1:0]  rs_next;
    reg  [TW-1:0]  rp_next;
    reg  [TW-1:0]  cs_next;
    reg  [TW-1:0]  cp_next;
    reg  [TW-1:0]  cyc_next;
    reg            take;
    reg            take_ok;
    reg            last;
    reg            capture;
    reg  [TW:0]    cap_at;

    wire [2:0]     req_sel;
    wire [1:0]     req_w;
    wire           req_bat;
    wire [3:0]     req_lanes;

    // address bits above the offset choose the select
    assign req_sel = req_addr[`SMC_SEL_LSB +: `SMC_SEL_W]; // RULE23
    assign req_w   = width_of(bus_width_field[2*req_sel[2:0] +: 2]); // RULE3

    // byte-write cannot serve as boot select, forced to byte-select
    assign req_bat = (boot_from_select0 && req_sel == 3'h0) ? // RULE6
                     `SMC_BAT_SELECT : byte_access_type[req_sel]; // RULE4
    assign req_lanes = lane_mask(req_size, req_addr[1:0], req_w);

    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        sel_next   = sel_reg;
        mode_next  = mode_reg;
        rs_next    = rs_reg;
        rp_next    = rp_reg;
        cs_next    = cs_reg;
        cp_next    = cp_reg;
        cyc_next   = cyc_reg;
        // cycle of zero counts as one, so the engine never stalls
        last = ({1'b0, cnt_reg} + {{TW{1'b0}}, 1'b1}) >= {1'b0, cyc_reg};
        take = req_valid && (state_reg == ST_IDLE || last);
        take_ok = take && (req_sel < NSEL); // RULE22
        // capture edge is the one that raises the governing strobe
        if (mode_reg) begin
            cap_at = {1'b0, rs_reg} + {1'b0, rp_reg}; // RULE19
        end else begin
            cap_at = {1'b0, cs_reg} + {1'b0, cp_reg}; // RULE20
        end
        capture = (state_reg == ST_READ) && // RULE18
                  ({1'b0, cnt_reg} + {{TW{1'b0}}, 1'b1} == cap_at);
        if (take_ok) begin
            // per select timings loaded for this cycle
            state_next = ST_READ;
            cnt_next   = {TW{1'b0}};
            sel_next   = req_sel;
            mode_next  = read_mode[req_sel];
            rs_next    = read_strobe_setup[TW*req_sel +: TW]; // RULE15
            rp_next    = read_strobe_pulse[TW*req_sel +: TW];
            cs_next    = select_read_setup[TW*req_sel +: TW]; // RULE13
            cp_next    = select_read_pulse[TW*req_sel +: TW];
            cyc_next   = read_cycle_length[TW*req_sel +: TW]; // RULE14
        end else if (state_reg == ST_READ && !last) begin
            cnt_next = cnt_reg + {{(TW-1){1'b0}}, 1'b1};
        end else if (state_reg == ST_READ) begin
            state_next = ST_IDLE;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= {TW{1'b0}};
            sel_reg   <= 3'h0;
            width_reg <= `SMC_WIDTH_8;
            mode_reg  <= 1'b1;
            rs_reg    <= {TW{1'b0}};
            rp_reg    <= {TW{1'b0}};
            cs_reg    <= {TW{1'b0}};
            cp_reg    <= {TW{1'b0}};
            cyc_reg   <= {TW{1'b0}};
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            sel_reg   <= sel_next;
            mode_reg  <= mode_next;
            rs_reg    <= rs_next;
            rp_reg    <= rp_next;
            cs_reg    <= cs_next;
            cp_reg    <= cp_next;
            cyc_reg   <= cyc_next;
            if (take_ok) begin
                width_reg <= req_w;
            end
        end
    end

    // strobes come straight from flops; with zero setup and hold a
    // following read re-enters the window and the pin never rises
    genvar gi;
    generate
        for (gi = 0; gi < NSEL; gi = gi + 1) begin : g_cs
            always @(posedge clk) begin
                if (sys_rst) begin
                    chip_select_n[gi] <= 1'b1;
                end else begin
                    chip_select_n[gi] <= !(state_next == ST_READ && // RULE16
                        sel_next == gi && // RULE13
                        in_window(cnt_next, cs_next, cp_next));
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (sys_rst) begin
            read_strobe_n <= 1'b1;
        end else begin
            read_strobe_n <= !(state_next == ST_READ && // RULE12
                in_window(cnt_next, rs_next, rp_next)); // RULE16
        end
    end

    // address and lane pins change only when a cycle starts, so lane
    // selects share the address timing exactly
    always @(posedge clk) begin
        if (sys_rst) begin
            mem_addr          <= 24'h000000;
            a0_lane0_select_n <= 1'b1;
            write_strobe_n    <= 1'b1;
            lane1_strobe_n    <= 1'b1;
            a1_lane2_strobe_n <= 1'b1;
            lane3_strobe_n    <= 1'b1;
        end else if (take_ok) begin // RULE10
            mem_addr       <= req_addr[25:2]; // RULE1
            // reads never pulse write strobes, shared or per lane
            write_strobe_n <= 1'b1; // RULE5
            lane3_strobe_n <= 1'b1;
            if (req_w == `SMC_WIDTH_8) begin
                a0_lane0_select_n <= req_addr[0]; // RULE11
                lane1_strobe_n    <= 1'b1; // RULE9
                a1_lane2_strobe_n <= req_addr[1]; // RULE2
            end else if (req_w == `SMC_WIDTH_16) begin
                a1_lane2_strobe_n <= req_addr[1]; // RULE8
                if (req_bat == `SMC_BAT_SELECT) begin
                    a0_lane0_select_n <= !req_lanes[0]; // RULE7
                    lane1_strobe_n    <= !req_lanes[1];
                end else begin
                    a0_lane0_select_n <= 1'b1; // RULE9
                    lane1_strobe_n    <= 1'b1;
                end
            end else if (req_bat == `SMC_BAT_SELECT) begin
                a0_lane0_select_n <= !req_lanes[0]; // RULE8
                lane1_strobe_n    <= !req_lanes[1];
                a1_lane2_strobe_n <= !req_lanes[2];
                lane3_strobe_n    <= !req_lanes[3];
            end else begin
                a0_lane0_select_n <= 1'b1; // RULE9
                lane1_strobe_n    <= 1'b1;
                a1_lane2_strobe_n <= 1'b1;
            end
        end
    end

    // request and answer side
    always @(posedge clk) begin
        if (sys_rst) begin
            req_ready  <= 1'b0;
            read_valid <= 1'b0;
            read_error <= 1'b0;
            read_data  <= 32'h00000000;
        end else begin
            req_ready  <= take;
            read_error <= take && !take_ok;
            read_valid <= capture || (take && !take_ok);
            if (capture) begin
                // narrow buses return their lanes zero-extended
                if (width_reg == `SMC_WIDTH_8) begin
                    read_data <= {24'h000000, mem_data_in[7:0]};
                end else if (width_reg == `SMC_WIDTH_16) begin
                    read_data <= {16'h0000, mem_data_in[15:0]};
                end else begin
                    read_data <= mem_data_in;
                end
            end else if (take && !take_ok) begin
                read_data <= 32'h00000000;
            end
        end
    end

endmodule // static_memory_read

// File: static_memory_read_and_byte_lanes_test.sv
// self-checking bench for the static memory read engine
`timescale 1ns/1ps
module static_memory_read_and_byte_lanes_test;
    reg         clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         boot_from_select0 = 1'b1;
    reg         req_valid = 1'b0;
    reg  [11:0] bus_width_field = 12'hE85;
    reg  [5:0]  byte_access_type = 6'h11;
    reg  [5:0]  read_mode = 6'h15;
    reg  [59:0] read_strobe_setup = {10'h0, 10'h2, 10'h1, 10'h0, 10'h1, 10'h1};
    reg  [59:0] read_strobe_pulse = {10'h1, 10'h3, 10'h2, 10'h2, 10'h3, 10'h2};
    reg  [59:0] select_read_setup = {10'h0, 10'h1, 10'h0, 10'h0, 10'h2, 10'h0};
    reg  [59:0] select_read_pulse = {10'h1, 10'h4, 10'h3, 10'h2, 10'h2, 10'h4};
    reg  [59:0] read_cycle_length = {10'h2, 10'h6, 10'h3, 10'h2, 10'h5, 10'h4};
    reg  [31:0] req_addr = 32'h0;
    reg  [1:0]  req_size = 2'h0;
    reg  [31:0] a_q;
    reg  [32:0] e;
    reg  [32:0] q[$];
    wire        req_ready, read_valid, read_error, read_strobe_n, write_strobe_n;
    wire        a0_lane0_select_n, lane1_strobe_n, a1_lane2_strobe_n, lane3_strobe_n;
    wire [31:0] read_data, mem_data_in;
    wire [5:0]  chip_select_n;
    wire [25:2] mem_addr;
    integer     fail_count = 0, check_count = 0, cyc = 0, i, n;

    always #5 clk = ~clk;
    static_memory_read u_dut (.*);
    sram_model u_mem (.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
        .mem_addr(mem_addr), .mem_data_in(mem_data_in));

    function [32:0] want(input [31:0] a);
        reg [1:0] w;
        begin
            w = bus_width_field[2*a[28:26] +: 2];
            if (a[28:26] > 3'h5) want = {1'b1, 32'h0};
            else want = {1'b0, {8'hC3, a[25:2]} &
                (w == 2'h0 ? 32'hFF : w == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF)};
        end
    endfunction

    // request is held until ready; a kept request runs straight into the next one
    task rd(input [31:0] a, input [1:0] z, input k);
        begin
            req_valid <= 1'b1;
            req_addr <= a;
            req_size <= z;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (req_ready !== 1'b1 && n < 50);
            if (n >= 50) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0t no ready", $time);
            end
            if (!k) begin
                req_valid <= 1'b0;
                @(posedge clk);
            end
        end
    endtask

    task end_of_test;
        begin
            if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask

    always @(posedge clk) begin
        a_q <= req_addr;
        cyc = cyc + 1;
        if (cyc == 2000) begin
            fail_count = fail_count + 1;
            end_of_test;
        end
        if (req_ready === 1'b1) q.push_back(want(a_q));
        if (read_valid === 1'b1) begin
            e = q.size() ? q.pop_front() : 33'h0;
            check_count = check_count + 1;
            if (read_error !== e[32] || (!e[32] && read_data !== e[31:0])) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0t read answer %h", $time, read_data);
            end
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i = i + 1) rd({i[2:0], 26'h1234560} + i, 2'h2, 1'b0);
        for (i = 0; i < 6; i = i + 1) rd({i[2:0], 26'h0ABCDE0} + i, 2'h0, 1'b0);
        rd(32'h0800_0010, 2'h2, 1'b1);
        rd(32'h0800_0023, 2'h0, 1'b0);
        boot_from_select0 <= 1'b0;
        rd(32'h0000_0042, 2'h1, 1'b0);
        repeat (20) @(posedge clk);
        check_count = check_count + 1;
        if (q.size() != 0) begin
            fail_count = fail_count + 1;
            $display("[ERR] %0t reads unanswered", $time);
        end
        end_of_test;
    end
endmodule // static_memory_read_and_byte_lanes_test
